// file: ogr_pkg.sv
package ogr_pkg;
  localparam int SAMPLE_W = 16;
  localparam int GAIN_W = 6;
  localparam int RAMP_W = 8;
  localparam int ADDR_W = 7;
  localparam int RAMP_PERIOD = 4;
  localparam int SPI_BITS = 16;
  localparam logic [4:0] SPI_CNT_INSTR_LAST = 5'h07;
  localparam logic [4:0] SPI_CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] SPI_CNT_LAST = 5'h0F;
  localparam logic [4:0] SPI_CNT_DONE = 5'h10;

  localparam logic [ADDR_W-1:0] ADDR_IQ_CFG = 7'h27;
  localparam logic [ADDR_W-1:0] ADDR_Q_OFFSET_LOW = 7'h3D;
  localparam logic [ADDR_W-1:0] ADDR_Q_OFFSET_HIGH = 7'h3E;
  localparam logic [ADDR_W-1:0] ADDR_I_GAIN = 7'h3F;
  localparam logic [ADDR_W-1:0] ADDR_Q_GAIN = 7'h40;
  localparam logic [ADDR_W-1:0] ADDR_RAMP_UP = 7'h41;
  localparam logic [ADDR_W-1:0] ADDR_RAMP_DOWN = 7'h42;
  localparam logic [ADDR_W-1:0] ADDR_TX_PIN = 7'h43;
  localparam logic [ADDR_W-1:0] ADDR_PROTECT = 7'h44;
  localparam logic [ADDR_W-1:0] ADDR_DELAY_CELL = 7'h5E;

  localparam logic [7:0] RST_IQ_CFG = 8'h00;
  localparam logic [7:0] RST_Q_OFFSET = 8'h00;
  localparam logic [GAIN_W-1:0] RST_GAIN = 6'h20;
  localparam logic [GAIN_W-1:0] RST_STEP = 6'h01;
  localparam logic [2:0] RST_TX_PIN = 3'h7;
  localparam logic [7:0] RST_PROTECT = 8'h8D;
  localparam logic [7:0] RST_DELAY_CELL = 8'hFF;

  localparam int BIT_IQ_GAIN_EN = 5;
  localparam int BIT_OUTPUT_OFF = 7;
  localparam int BIT_OUTPUT_STATUS = 6;
  localparam int BIT_PIN_RAMP_EN = 2;
  localparam int BIT_PIN_SLEEP_EN = 1;
  localparam int BIT_PIN_PWRDN_EN = 0;
  localparam int BIT_PROT_MASTER = 7;
  localparam int BIT_BUF_WARN_CUT = 3;
  localparam int BIT_POWER_CUT = 2;
  localparam int BIT_BUF_ERR_CUT = 0;
  localparam logic [7:0] PROTECT_MASK = 8'h8D;

  localparam int PIN_TRANSMIT_GATE_PIN = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SDIO = 3;
  localparam logic [3:0] PIN_RST = 4'h2;

  typedef enum logic [1:0] {OGR_OFF, OGR_UP, OGR_ON, OGR_DOWN} ogr_ramp_state_t;
endpackage

// file: ogr_tick_if.sv
`timescale 1ns/1ps
interface ogr_tick_if;
  logic tick;
  modport gen (output tick);
  modport use_tick (input tick);
endinterface

// file: ogr_tick_gen.sv
`timescale 1ns/1ps
module ogr_tick_gen #(
  parameter int PERIOD = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  ogr_tick_if.gen tk
);
  localparam int CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  always_comb begin
    next_cnt = (cnt == LAST) ? '0 : cnt + CW'(1);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // One pulse in every PERIOD cycles paces the gain steps.
  assign tk.tick = (cnt == LAST);

  property p_tick_period;
    @(posedge clk_i) disable iff (!rst_n_i) tk.tick |=> !tk.tick [*3] ##1 tk.tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("Step pulse period is not four cycles."); // RL4
endmodule

// file: ogr_gain_ramp.sv
`timescale 1ns/1ps
// Operation
// [RL1] I samples scale by six-bit gain, weight 2^0 to 2^-5, reset unity.
// [RL2] Q samples scale by their own six-bit gain, same weighting, reset unity; the code uses the smaller of the Q gain and the running gain.
// [RL3] Sixteen-bit Q offset from two bytes is added to every Q sample.
// [RL4] Turning on raises gain by the up step every four cycles to I gain.
// [RL5] Turning off lowers gain by the down step every four cycles to zero.
// [RL6] Software keeps both step values no larger than the I gain.
// [RL7] Manual off bit switches output, only with the IQ gain function enabled.
// [RL8] Read-only status bit is one while output off, one after reset; the code updates it only with the IQ gain function enabled.
// [RL9] With pin ramp enable set, output ramps on and off with the pin.
// [RL10] With sleep enable set, a low transmit pin requests sleep.
// [RL11] With power-down enable set, a low transmit pin requests power-down.
// [RL12] Protection master enable gates every automatic shutdown condition.
// [RL13] Master and buffer warning enable set: a buffer warning shuts output down.
// [RL14] Power limit enable set: over-threshold average power turns output off.
// [RL15] Buffer error enable set: buffer warnings turn output off.
// [RL16] Running gain never overshoots the target nor drops below zero.
// [RL17] While shut down, both outputs carry zero samples.
module ogr_gain_ramp (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic signed [ogr_pkg::SAMPLE_W-1:0] i_sample_i,
  input wire logic signed [ogr_pkg::SAMPLE_W-1:0] q_sample_i,
  input wire logic buffer_warning_i,
  input wire logic power_over_threshold_i,
  input wire logic transmit_gate_pin_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe_n_o,
  output logic signed [ogr_pkg::SAMPLE_W-1:0] i_out_o,
  output logic signed [ogr_pkg::SAMPLE_W-1:0] q_out_o,
  output logic sleep_o,
  output logic power_down_o,
  output logic [7:0] delay_cell_enable_low_o
);
  import ogr_pkg::*;

  ogr_tick_if tk_if ();
  ogr_tick_gen #(.PERIOD(RAMP_PERIOD)) u_tick (.clk_i(clk_i), .rst_n_i(rst_n_i), .tk(tk_if.gen));

  // Pins pass three flops; a level is accepted once the last two agree.
  logic [3:0] pin_ff1, pin_ff2, pin_ff3, pin_stable, pin_prev;
  logic [3:0] next_pin_stable;
  always_comb begin
    next_pin_stable = pin_stable;
    for (int k = 0; k < 4; k++) begin
      if (pin_ff2[k] == pin_ff3[k]) begin
        next_pin_stable[k] = pin_ff3[k];
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_ff1 <= PIN_RST;
      pin_ff2 <= PIN_RST;
      pin_ff3 <= PIN_RST;
      pin_stable <= PIN_RST;
      pin_prev <= PIN_RST;
    end else begin
      pin_ff1 <= {spi_sdio_i, spi_sclk_i, spi_cs_n_i, transmit_gate_pin_i};
      pin_ff2 <= pin_ff1;
      pin_ff3 <= pin_ff2;
      pin_stable <= next_pin_stable;
      pin_prev <= pin_stable;
    end
  end
  logic transmit_gate_signal, cs_n, sclk_rise, sclk_fall;
  assign transmit_gate_signal = pin_stable[PIN_TRANSMIT_GATE_PIN];
  assign cs_n = pin_stable[PIN_CS_N];
  assign sclk_rise = pin_stable[PIN_SCLK] & ~pin_prev[PIN_SCLK];
  assign sclk_fall = ~pin_stable[PIN_SCLK] & pin_prev[PIN_SCLK];

  // Register file.
  logic [7:0] iq_cfg, q_offset_low, q_offset_high_register, protect, delay_cell_enable_low;
  logic [GAIN_W-1:0] i_gain_value, q_gain_value, ramp_up_register, ramp_down_register;
  logic output_off, output_status;
  logic [2:0] tx_pin;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] next_iq_cfg, next_q_offset_low, next_q_offset_high_register, next_protect, next_delay_cell;
  logic [GAIN_W-1:0] next_i_gain, next_q_gain, next_up, next_down;
  logic next_output_off;
  logic [2:0] next_tx_pin;

  always_comb begin
    next_iq_cfg = iq_cfg;
    next_q_offset_low = q_offset_low;
    next_q_offset_high_register = q_offset_high_register;
    next_i_gain = i_gain_value;
    next_q_gain = q_gain_value;
    next_up = ramp_up_register;
    next_down = ramp_down_register;
    next_output_off = output_off;
    next_tx_pin = tx_pin;
    next_protect = protect;
    next_delay_cell = delay_cell_enable_low;
    if (wr_en) begin
      if (wr_addr == ADDR_IQ_CFG) begin
        next_iq_cfg = wr_data;
      end else if (wr_addr == ADDR_Q_OFFSET_LOW) begin
        next_q_offset_low = wr_data;
      end else if (wr_addr == ADDR_Q_OFFSET_HIGH) begin
        next_q_offset_high_register = wr_data;
      end else if (wr_addr == ADDR_I_GAIN) begin
        next_i_gain = wr_data[GAIN_W-1:0];
      end else if (wr_addr == ADDR_Q_GAIN) begin
        next_q_gain = wr_data[GAIN_W-1:0];
      end else if (wr_addr == ADDR_RAMP_UP) begin
        next_up = wr_data[GAIN_W-1:0];
      end else if (wr_addr == ADDR_RAMP_DOWN) begin
        next_down = wr_data[GAIN_W-1:0];
        next_output_off = wr_data[BIT_OUTPUT_OFF];
      end else if (wr_addr == ADDR_TX_PIN) begin
        next_tx_pin = wr_data[2:0];
      end else if (wr_addr == ADDR_PROTECT) begin
        next_protect = wr_data & PROTECT_MASK;
      end else if (wr_addr == ADDR_DELAY_CELL) begin
        next_delay_cell = wr_data;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      iq_cfg <= RST_IQ_CFG;
      q_offset_low <= RST_Q_OFFSET;
      q_offset_high_register <= RST_Q_OFFSET;
      i_gain_value <= RST_GAIN;
      q_gain_value <= RST_GAIN;
      ramp_up_register <= RST_STEP;
      ramp_down_register <= RST_STEP;
      output_off <= 1'b0;
      tx_pin <= RST_TX_PIN;
      protect <= RST_PROTECT;
      delay_cell_enable_low <= RST_DELAY_CELL;
    end else begin
      iq_cfg <= next_iq_cfg;
      q_offset_low <= next_q_offset_low;
      q_offset_high_register <= next_q_offset_high_register;
      i_gain_value <= next_i_gain;
      q_gain_value <= next_q_gain;
      ramp_up_register <= next_up;
      ramp_down_register <= next_down;
      output_off <= next_output_off;
      tx_pin <= next_tx_pin;
      protect <= next_protect;
      delay_cell_enable_low <= next_delay_cell;
    end
  end
  assign delay_cell_enable_low_o = delay_cell_enable_low;

  function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == ADDR_IQ_CFG) begin
      d = iq_cfg;
    end else if (a == ADDR_Q_OFFSET_LOW) begin
      d = q_offset_low;
    end else if (a == ADDR_Q_OFFSET_HIGH) begin
      d = q_offset_high_register;
    end else if (a == ADDR_I_GAIN) begin
      d = {2'h0, i_gain_value};
    end else if (a == ADDR_Q_GAIN) begin
      d = {2'h0, q_gain_value};
    end else if (a == ADDR_RAMP_UP) begin
      d = {2'h0, ramp_up_register};
    end else if (a == ADDR_RAMP_DOWN) begin
      d = {output_off, output_status, ramp_down_register}; // RL8
    end else if (a == ADDR_TX_PIN) begin
      d = {5'h00, tx_pin};
    end else if (a == ADDR_PROTECT) begin
      d = protect;
    end else if (a == ADDR_DELAY_CELL) begin
      d = delay_cell_enable_low;
    end
    return d;
  endfunction

  // Three-wire serial port: R/W bit, seven address bits, eight data bits, MSB first.
  logic [4:0] spi_cnt, next_spi_cnt;
  logic [SPI_BITS-1:0] spi_in, next_spi_in;
  logic [7:0] spi_out, next_spi_out;
  logic spi_rd, next_spi_rd, next_sdio;
  always_comb begin
    next_spi_cnt = spi_cnt;
    next_spi_in = spi_in;
    next_spi_out = spi_out;
    next_spi_rd = spi_rd;
    next_sdio = spi_sdio_o;
    wr_en = 1'b0;
    wr_addr = spi_in[13:7];
    wr_data = {spi_in[6:0], pin_stable[PIN_SDIO]};
    if (cs_n) begin
      next_spi_cnt = '0;
      next_spi_rd = 1'b0;
    end else if (sclk_rise) begin
      next_spi_in = {spi_in[SPI_BITS-2:0], pin_stable[PIN_SDIO]};
      if (spi_cnt != SPI_CNT_DONE) begin
        next_spi_cnt = spi_cnt + 5'h01;
      end
      if (spi_cnt == SPI_CNT_INSTR_LAST) begin
        next_spi_rd = spi_in[6];
        next_spi_out = read_reg({spi_in[5:0], pin_stable[PIN_SDIO]});
      end
      wr_en = (spi_cnt == SPI_CNT_LAST) && !spi_rd;
    end else if (sclk_fall && spi_rd && spi_cnt >= SPI_CNT_DATA_FIRST) begin
      next_sdio = spi_out[7];
      next_spi_out = {spi_out[6:0], 1'b0};
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spi_cnt <= '0;
      spi_in <= '0;
      spi_out <= '0;
      spi_rd <= 1'b0;
      spi_sdio_o <= 1'b0;
    end else begin
      spi_cnt <= next_spi_cnt;
      spi_in <= next_spi_in;
      spi_out <= next_spi_out;
      spi_rd <= next_spi_rd;
      spi_sdio_o <= next_sdio;
    end
  end
  assign spi_sdio_oe_n_o = !(spi_rd && !cs_n);

  // Output on/off decision and gain ramp.
  logic iq_gain_en, manual_off, pin_off, auto_cut, want_on;
  assign iq_gain_en = iq_cfg[BIT_IQ_GAIN_EN];
  assign manual_off = iq_gain_en && output_off; // RL7
  assign pin_off = tx_pin[BIT_PIN_RAMP_EN] && !transmit_gate_signal; // RL9
  assign auto_cut = protect[BIT_PROT_MASTER] && ( // RL12
      ((protect[BIT_BUF_WARN_CUT] || protect[BIT_BUF_ERR_CUT]) && buffer_warning_i) || // RL13 RL15
      (protect[BIT_POWER_CUT] && power_over_threshold_i)); // RL14
  assign want_on = !manual_off && !pin_off && !auto_cut;

  ogr_ramp_state_t state, next_state;
  logic [RAMP_W-1:0] ramp_gain, next_ramp_gain, target, up_inc, down_dec;
  logic next_output_status, next_sleep, next_power_down;
  // Steps carry one fewer fractional bit of weight than the gain, hence the doubling.
  assign target = {2'h0, i_gain_value};
  assign up_inc = {1'b0, ramp_up_register, 1'b0};
  assign down_dec = {1'b0, ramp_down_register, 1'b0};

  always_comb begin
    next_state = state;
    next_ramp_gain = ramp_gain;
    case (state)
      OGR_OFF: begin
        next_ramp_gain = '0;
        if (want_on) begin
          next_state = OGR_UP;
        end
      end
      OGR_UP: begin
        if (!want_on) begin
          next_state = OGR_DOWN;
        end else if (tk_if.tick) begin
          if ({1'b0, ramp_gain} + {1'b0, up_inc} >= {1'b0, target}) begin
            next_ramp_gain = target; // RL16
            next_state = OGR_ON;
          end else begin
            next_ramp_gain = ramp_gain + up_inc; // RL4
          end
        end
      end
      OGR_ON: begin
        next_ramp_gain = target;
        if (!want_on) begin
          next_state = OGR_DOWN;
        end
      end
      default: begin
        if (want_on) begin
          next_state = OGR_UP;
        end else if (tk_if.tick) begin
          if (ramp_gain <= down_dec) begin
            next_ramp_gain = '0; // RL16
            next_state = OGR_OFF;
          end else begin
            next_ramp_gain = ramp_gain - down_dec; // RL5
          end
        end
      end
    endcase
    next_output_status = iq_gain_en ? (next_state == OGR_OFF) : output_status; // RL8
    next_sleep = tx_pin[BIT_PIN_SLEEP_EN] && !transmit_gate_signal; // RL10
    next_power_down = tx_pin[BIT_PIN_PWRDN_EN] && !transmit_gate_signal; // RL11
  end

  // Datapath: gains have five fractional bits, results saturate to the sample range.
  function automatic logic signed [SAMPLE_W-1:0] sat(input logic signed [25:0] v);
    logic signed [25:0] hi, lo;
    hi = 26'sh0007FFF;
    lo = -26'sh0008000;
    if (v > hi) begin
      return hi[SAMPLE_W-1:0];
    end else if (v < lo) begin
      return lo[SAMPLE_W-1:0];
    end
    return v[SAMPLE_W-1:0];
  endfunction

  logic [GAIN_W-1:0] gain_i, gain_q;
  logic signed [25:0] prod_i, prod_q, q_sum;
  logic signed [SAMPLE_W-1:0] next_i_out, next_q_out;
  always_comb begin
    gain_i = ramp_gain[GAIN_W-1:0]; // RL1
    gain_q = (ramp_gain >= {2'h0, q_gain_value}) ? q_gain_value : ramp_gain[GAIN_W-1:0]; // RL2
    prod_i = (26'(i_sample_i) * 26'(signed'({1'b0, gain_i}))) >>> 5;
    prod_q = (26'(q_sample_i) * 26'(signed'({1'b0, gain_q}))) >>> 5;
    q_sum = 26'(sat(prod_q)) + 26'(signed'({q_offset_high_register, q_offset_low})); // RL3
    next_i_out = sat(prod_i);
    next_q_out = sat(q_sum);
    if (state == OGR_OFF) begin
      next_i_out = '0; // RL17
      next_q_out = '0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= OGR_OFF;
      ramp_gain <= '0;
      output_status <= 1'b1;
      sleep_o <= 1'b0;
      power_down_o <= 1'b0;
      i_out_o <= '0;
      q_out_o <= '0;
    end else begin
      state <= next_state;
      ramp_gain <= next_ramp_gain;
      output_status <= next_output_status;
      sleep_o <= next_sleep;
      power_down_o <= next_power_down;
      i_out_o <= next_i_out;
      q_out_o <= next_q_out;
    end
  end

  property p_off_zero;
    @(posedge clk_i) disable iff (!rst_n_i) state == OGR_OFF |=> i_out_o == '0 && q_out_o == '0;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("Output not zero while off."); // RL17
  property p_up_step;
    @(posedge clk_i) disable iff (!rst_n_i) state == OGR_UP && want_on && tk_if.tick
      && ({1'b0, ramp_gain} + {1'b0, up_inc} < {1'b0, target}) |=> ramp_gain == $past(ramp_gain) + $past(up_inc);
  endproperty
  a_up_step: assert property (p_up_step) else $error("Ramp up step wrong."); // RL4
  property p_down_step;
    @(posedge clk_i) disable iff (!rst_n_i) state == OGR_DOWN && !want_on && tk_if.tick && ramp_gain > down_dec
      |=> ramp_gain == $past(ramp_gain) - $past(down_dec);
  endproperty
  a_down_step: assert property (p_down_step) else $error("Ramp down step wrong."); // RL5
  property p_no_overshoot;
    @(posedge clk_i) disable iff (!rst_n_i) state == OGR_UP && $stable(target) |=> ramp_gain <= target;
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("Gain overshot target."); // RL16
  property p_status;
    @(posedge clk_i) disable iff (!rst_n_i) iq_gain_en && state == OGR_OFF && !want_on |=> output_status;
  endproperty
  a_status: assert property (p_status) else $error("Status not set while off."); // RL8
  property p_pin_off;
    @(posedge clk_i) disable iff (!rst_n_i) tx_pin[BIT_PIN_RAMP_EN] && !transmit_gate_signal && state == OGR_ON
      |=> state == OGR_DOWN;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("Pin low did not start ramp down."); // RL9
  property p_sleep;
    @(posedge clk_i) disable iff (!rst_n_i) tx_pin[BIT_PIN_SLEEP_EN] && !transmit_gate_signal |=> sleep_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep not requested."); // RL10
  // With the master enable clear, warnings and power alarms must not take a running output down.
  property p_master;
    @(posedge clk_i) disable iff (!rst_n_i) !protect[BIT_PROT_MASTER] && !manual_off && !pin_off
      && state == OGR_ON |=> state == OGR_ON;
  endproperty
  a_master: assert property (p_master) else $error("Shutdown acted without master enable."); // RL12
  property p_warn_cut;
    @(posedge clk_i) disable iff (!rst_n_i) protect[BIT_PROT_MASTER] && protect[BIT_BUF_WARN_CUT] && buffer_warning_i
      && state == OGR_ON |=> state == OGR_DOWN;
  endproperty
  a_warn_cut: assert property (p_warn_cut) else $error("Buffer warning did not shut output."); // RL13
  c_reach_on: cover property (@(posedge clk_i) disable iff (!rst_n_i) state == OGR_UP ##1 state == OGR_ON);
  c_reach_off: cover property (@(posedge clk_i) disable iff (!rst_n_i) state == OGR_DOWN ##1 state == OGR_OFF);
  c_spi_write: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_en);
endmodule

// file: ogr_host_model.sv
`timescale 1ns/1ps
module ogr_host_model (
  input wire logic clk_i,
  input wire logic sdio_line_i,
  output logic spi_cs_n_o,
  output logic spi_sclk_o,
  output logic spi_sdio_o,
  output logic spi_sdio_en_o,
  output logic signed [ogr_pkg::SAMPLE_W-1:0] i_sample_o,
  output logic signed [ogr_pkg::SAMPLE_W-1:0] q_sample_o,
  output logic transmit_gate_pin_o
);
  import ogr_pkg::*;
  // Each serial clock level lasts eight cycles, twice the device's minimum.
  localparam int HALF = 8;
  initial begin
    spi_cs_n_o = 1'b1;
    spi_sclk_o = 1'b0;
    spi_sdio_o = 1'b0;
    spi_sdio_en_o = 1'b1;
    i_sample_o = '0;
    q_sample_o = '0;
    transmit_gate_pin_o = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic drive(input logic [15:0] i, input logic [15:0] q, input logic pin);
    step(1);
    i_sample_o = i;
    q_sample_o = q;
    transmit_gate_pin_o = pin;
  endtask
  // Read data is taken at the moment the serial clock is raised.
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] wd, output logic [7:0] rdata);
    logic [15:0] word;
    word = {rd, a, wd};
    rdata = 8'h00;
    step(1);
    spi_cs_n_o = 1'b0;
    for (int b = 15; b >= 0; b--) begin
      if (rd && b < 8) spi_sdio_en_o = 1'b0;
      else spi_sdio_o = word[b];
      step(HALF);
      if (rd && b < 8) rdata[b] = sdio_line_i;
      spi_sclk_o = 1'b1;
      step(HALF);
      spi_sclk_o = 1'b0;
    end
    step(HALF);
    spi_sdio_en_o = 1'b1;
    spi_cs_n_o = 1'b1;
    step(HALF);
  endtask
endmodule

// file: ogr_gain_ramp_tb_top.sv
`timescale 1ns/1ps
module ogr_gain_ramp_tb_top;
  import ogr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic warn = 1'b0;
  logic over = 1'b0;
  logic cs_n, sclk, h_sdio, h_en, d_sdio, d_oe_n, line, pin, sleep, pdown;
  logic signed [SAMPLE_W-1:0] i_smp, q_smp, i_out, q_out;
  logic [7:0] dcell;
  int err_count = 0;
  int comparisons = 0;
  always #50 clk_i = ~clk_i;
  // A released line shows the inverse of the host's last bit.
  assign line = !d_oe_n ? d_sdio : (h_en ? h_sdio : ~h_sdio);
  ogr_host_model host (.clk_i(clk_i), .sdio_line_i(line), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk),
    .spi_sdio_o(h_sdio), .spi_sdio_en_o(h_en), .i_sample_o(i_smp), .q_sample_o(q_smp), .transmit_gate_pin_o(pin));
  ogr_gain_ramp uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .i_sample_i(i_smp), .q_sample_i(q_smp),
    .buffer_warning_i(warn), .power_over_threshold_i(over), .transmit_gate_pin_i(pin), .spi_cs_n_i(cs_n),
    .spi_sclk_i(sclk), .spi_sdio_i(line), .spi_sdio_o(d_sdio), .spi_sdio_oe_n_o(d_oe_n), .i_out_o(i_out),
    .q_out_o(q_out), .sleep_o(sleep), .power_down_o(pdown), .delay_cell_enable_low_o(dcell));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(1'b0, a, d, x);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    logic [7:0] x;
    host.xfer(1'b1, a, 8'h00, x);
    chk({8'h00, x}, {8'h00, e});
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // With a sample of 0x20 the I output equals the running gain.
  task automatic cap(input logic [15:0] e [6], input int n);
    logic [15:0] prev;
    int k, last;
    prev = i_out;
    k = 0;
    last = 0;
    for (int c = 0; c < 200 && k < n; c++) begin
      @(negedge clk_i);
      if (i_out !== prev) begin
        chk(i_out, e[k]);
        if (k > 0) chk(16'(c - last), 16'(RAMP_PERIOD));
        prev = i_out;
        last = c;
        k++;
      end
    end
    chk(16'(k), 16'(n));
  endtask
  task automatic t_reset_values;
    logic [ADDR_W-1:0] a [11] = '{ADDR_IQ_CFG, ADDR_Q_OFFSET_LOW, ADDR_Q_OFFSET_HIGH, ADDR_I_GAIN, ADDR_Q_GAIN,
      ADDR_RAMP_UP, ADDR_RAMP_DOWN, ADDR_TX_PIN, ADDR_PROTECT, ADDR_DELAY_CELL, 7'h10};
    logic [7:0] e [11] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h20, 8'h01, 8'h41, 8'h07, 8'h8D, 8'hFF, 8'h00};
    for (int k = 0; k < 11; k++) rd(a[k], e[k]);
    chk({8'h00, dcell}, 16'h00FF);
  endtask
  task automatic t_datapath;
    logic [15:0] s [4][4] = '{'{16'h1000, 16'h1000, 16'h1F80, 16'h1634}, '{16'hF000, 16'hF000, 16'hE080, 16'h0E34},
      '{16'h7000, 16'h0000, 16'h7FFF, 16'h1234}, '{16'h9000, 16'h7FFF, 16'h8000, 16'h3233}};
    wr(ADDR_I_GAIN, 8'h3F);
    wr(ADDR_Q_GAIN, 8'h08);
    wr(ADDR_Q_OFFSET_LOW, 8'h34);
    wr(ADDR_Q_OFFSET_HIGH, 8'h12);
    for (int k = 0; k < 4; k++) begin
      host.drive(s[k][0], s[k][1], 1'b1);
      settle(3);
      chk(i_out, s[k][2]);
      chk(q_out, s[k][3]);
    end
    wr(ADDR_I_GAIN, 8'h20);
    wr(ADDR_Q_GAIN, 8'h20);
  endtask
  task automatic t_ramp;
    host.drive(16'h0020, 16'h0000, 1'b1);
    wr(ADDR_RAMP_UP, 8'h05);
    wr(ADDR_RAMP_DOWN, 8'h03);
    chk(i_out, 16'h0020);
    host.drive(16'h0020, 16'h0000, 1'b0);
    cap('{16'h1A, 16'h14, 16'h0E, 16'h08, 16'h02, 16'h00}, 6);
    chk({15'h0, sleep}, 16'h1);
    chk({15'h0, pdown}, 16'h1);
    chk(q_out, 16'h0000);
    host.drive(16'h0020, 16'h0000, 1'b1);
    cap('{16'h0A, 16'h14, 16'h1E, 16'h20, 16'h0, 16'h0}, 4);
    chk({14'h0, sleep, pdown}, 16'h0);
    wr(ADDR_TX_PIN, 8'h02);
    host.drive(16'h0020, 16'h0000, 1'b0);
    settle(30);
    chk(i_out, 16'h0020);
    chk({14'h0, sleep, pdown}, 16'h2);
    wr(ADDR_TX_PIN, 8'h01);
    chk({14'h0, sleep, pdown}, 16'h1);
    host.drive(16'h0020, 16'h0000, 1'b1);
    wr(ADDR_TX_PIN, 8'h07);
  endtask
  task automatic t_manual;
    wr(ADDR_RAMP_UP, 8'h10);
    wr(ADDR_RAMP_DOWN, 8'h90);
    chk(i_out, 16'h0020);
    rd(ADDR_RAMP_DOWN, 8'hD0);
    wr(ADDR_IQ_CFG, 8'h20);
    chk(i_out, 16'h0000);
    chk(q_out, 16'h0000);
    rd(ADDR_RAMP_DOWN, 8'hD0);
    wr(ADDR_RAMP_DOWN, 8'h50);
    chk(i_out, 16'h0020);
    rd(ADDR_RAMP_DOWN, 8'h10);
    wr(ADDR_IQ_CFG, 8'h00);
  endtask
  task automatic t_protect;
    logic [7:0] c [8] = '{8'h8D, 8'h8D, 8'h0D, 8'h84, 8'h84, 8'h88, 8'h81, 8'h80};
    logic [2:0] f [8] = '{3'b101, 3'b011, 3'b110, 3'b100, 3'b011, 3'b101, 3'b101, 3'b110};
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_PROTECT, c[k]);
      host.step(1);
      {warn, over} = f[k][2:1];
      settle(20);
      chk(i_out, f[k][0] ? 16'h0 : 16'h0020);
      chk(q_out, f[k][0] ? 16'h0 : 16'h1234);
      host.step(1);
      {warn, over} = 2'b00;
      settle(20);
    end
  endtask
  task automatic close_out;
    $display("err_count=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    close_out;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    host.step(2);
    t_reset_values;
    t_datapath;
    t_ramp;
    t_manual;
    t_protect;
    close_out;
  end
endmodule
